//--- core/glyph_attr_pkg.sv
// shared constants and carriers for the polyline and glyph pixel unit
`default_nettype none
package glyph_attr_pkg;
	localparam int WORD_W = 32;
	localparam int ADR_W = 8;
	// register byte offsets
	localparam logic [ADR_W-1:0] OFS_OPERATION_BIT_MASK = 8'h00;
	localparam logic [ADR_W-1:0] OFS_COMBO = 8'h04;
	localparam logic [ADR_W-1:0] OFS_LINE_CTRL = 8'h08;
	localparam logic [ADR_W-1:0] OFS_LINE_FG = 8'h0C;
	localparam logic [ADR_W-1:0] OFS_LINE_BG = 8'h10;
	localparam logic [ADR_W-1:0] OFS_LINE_STYLE = 8'h14;
	localparam logic [ADR_W-1:0] OFS_CHAR_CTRL = 8'h18;
	localparam logic [ADR_W-1:0] OFS_CHAR_FG = 8'h1C;
	localparam logic [ADR_W-1:0] OFS_CHAR_BG = 8'h20;
	localparam logic [ADR_W-1:0] OFS_FORM_MASK = 8'h24;
	localparam logic [ADR_W-1:0] OFS_CONTROL = 8'h28;
	localparam logic [ADR_W-1:0] OFS_STATUS = 8'h2C;
	localparam logic [ADR_W-1:0] OFS_PTR_BASE = 8'h40;
	localparam logic [ADR_W-1:0] OFS_PAL_BASE = 8'h80;
	localparam int PTR_WORDS = 9;
	localparam int PAL_WORDS = 4;
	// field positions
	localparam int LC_SUP_FG = 0;
	localparam int LC_SUP_BG = 1;
	localparam int LC_SUP_INIT = 2;
	localparam int LC_SUP_FINAL = 3;
	localparam int CC_SUP_FG = 0;
	localparam int CC_SUP_BG = 1;
	localparam int PF_VISIBLE = 0;
	localparam int PF_CROSS = 1;
	localparam int PF_IMAGE = 2;
	localparam int CTL_START = 0;
	localparam int ST_HIT = 0;
	localparam int ST_IDX_LO = 8;
	localparam int ST_WORD_IDX = 2;
	localparam int ST_WORD_PSEL = 5;
	// descriptor word positions
	localparam int PD_FLAGS = 0;
	localparam int PD_HSX = 1;
	localparam int PD_HSY = 2;
	localparam int PD_HEX = 3;
	localparam int PD_HEY = 4;
	localparam int PD_VSX = 5;
	localparam int PD_VSY = 6;
	localparam int PD_VEX = 7;
	localparam int PD_VEY = 8;
	localparam int PD_LEFT = 1;
	localparam int PD_TOP = 2;
	localparam int PD_WIDTH = 3;
	localparam int PD_HEIGHT = 4;
	// reset values
	localparam logic [WORD_W-1:0] RST_ZERO = 32'h0000_0000;
	localparam logic [WORD_W-1:0] RST_ONES = 32'hFFFF_FFFF;
	localparam logic [3:0] RULE_COPY = 4'h3;
	localparam logic [4:0] PAT_MSB = 5'h1F;
	localparam logic [4:0] PAT_LSB = 5'h00;
	localparam logic [4:0] PAT_STEP = 5'h01;

	typedef struct packed {
		logic is_char;
		logic cell_bit;
		logic first_pt;
		logic last_pt;
		logic signed [WORD_W-1:0] x;
		logic signed [WORD_W-1:0] y;
		logic [WORD_W-1:0] dest;
	} pix_req_s;

	typedef struct packed {
		logic [WORD_W-1:0] style;
		logic [WORD_W-1:0] fg;
		logic [WORD_W-1:0] bg;
	} seg_attr_s;
endpackage
`default_nettype wire

//--- core/glyph_pixel_attr.sv
// pixel attribute unit for polyline and glyph drawing with pointer guard
//
// Design decisions made here: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - style is 32 bits, one bit per line pixel, msb first
// - style bit one plants line foreground, zero plants line background
// - after the lsb the pattern pointer wraps to the msb
// - pattern runs on across segments, no restart at boundaries
// - suppressed pixels are not written at all
// - line control bits 0..3 suppress fg, bg, initial, final points
// - single point drawn only when both endpoint suppress bits are clear
// - a shared vertex takes the trailing segment attributes
// - packet attributes overwrite the line style and colour words
// - every planted colour goes through masks and combination rule
// - out = (mask and rule(src,dst)) or (not mask and dst)
// - glyph cell one writes char fg, zero writes char bg
// - char control bits 0,1 suppress glyph fg and bg pixels
// - a pixel that may hit the visible pointer stops the command
// - pointer flag bit 0 marks the pointer visible
// - cross-hair descriptor is nine words: flags and eight coordinates
// - image descriptor: flags, left, top, width, height
// - cross-hair endpoints are clipped to the screen edges
// - colour descriptor is red, green, blue and grey words
// - descriptor holds palette entries up to 128 bits
// - palette bits sit leftmost, unused bits read as zero
module glyph_pixel_attr
	import glyph_attr_pkg::*;
#(
	parameter int PAL_W = 8,
	parameter int SCREEN_W = 1024,
	parameter int SCREEN_H = 768
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic wb_cyc_in,
	input wire logic wb_stb_in,
	input wire logic wb_we_in,
	input wire logic [ADR_W-1:0] wb_adr_in,
	input wire logic [3:0] wb_sel_in,
	input wire logic [WORD_W-1:0] wb_dat_in,
	output logic wb_ack_out,
	output logic [WORD_W-1:0] wb_dat_out,
	input wire logic pix_valid_in,
	input wire pix_req_s pix_in,
	input wire logic seg_valid_in,
	input wire seg_attr_s seg_in,
	output logic pix_done_out,
	output logic pix_we_out,
	output logic [WORD_W-1:0] pix_data_out,
	output logic pointer_hit_out
);
	localparam logic signed [WORD_W-1:0] MAX_X = WORD_W'(SCREEN_W - 1);
	localparam logic signed [WORD_W-1:0] MAX_Y = WORD_W'(SCREEN_H - 1);

	// ==========================================================
	// helpers
	function automatic logic [WORD_W-1:0] apply_rule(
		input logic [3:0] rule,
		input logic [WORD_W-1:0] s,
		input logic [WORD_W-1:0] d);
		logic [WORD_W-1:0] r;
		r = '0;
		for (int i = 0; i < WORD_W; i++) begin
			r[i] = rule[{~s[i], ~d[i]}];
		end
		return r;
	endfunction

	function automatic logic in_span(
		input logic signed [WORD_W-1:0] v,
		input logic signed [WORD_W-1:0] a,
		input logic signed [WORD_W-1:0] b);
		return (v >= a) && (v <= b);
	endfunction

	function automatic logic [WORD_W-1:0] merge(
		input logic [WORD_W-1:0] old,
		input logic [WORD_W-1:0] nw,
		input logic [3:0] sel);
		logic [WORD_W-1:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// clip a coordinate into the visible screen
	function automatic logic [WORD_W-1:0] clip(
		input logic signed [WORD_W-1:0] v,
		input logic signed [WORD_W-1:0] hi);
		if (v < 0) begin
			return RST_ZERO;
		end
		if (v > hi) begin
			return hi;
		end
		return v;
	endfunction

	// ==========================================================
	// wishbone slave
	logic ack_ff;
	logic [WORD_W-1:0] rdat_ff;
	logic [WORD_W-1:0] operation_bit_mask_ff, form_mask_ff, line_fg_ff, line_bg_ff;
	logic [WORD_W-1:0] style_ff, char_fg_ff, char_bg_ff;
	logic [3:0] combo_ff;
	logic [WORD_W-1:0] line_ctrl_ff, char_ctrl_ff;
	logic [WORD_W-1:0] ptr_ff [PTR_WORDS];
	logic [PAL_W-1:0] pal_ff [PAL_WORDS];
	logic [4:0] pat_idx_ff;
	logic hit_ff;
	logic req, wr_now;
	logic start_cmd, hit_clear;
	logic [WORD_W-1:0] nxt_rdat;
	logic [WORD_W-1:0] wdat;

	assign req = wb_cyc_in && wb_stb_in;
	// writes land on the edge where the master sees ack
	assign wr_now = req && ack_ff && wb_we_in;
	assign wdat = wb_dat_in;
	assign start_cmd = wr_now && (wb_adr_in == OFS_CONTROL) &&
		wb_sel_in[0] && wdat[CTL_START];
	assign hit_clear = wr_now && (wb_adr_in == OFS_STATUS) &&
		wb_sel_in[0] && wdat[ST_HIT];

	// ack one cycle after the request, dropped the cycle after
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			ack_ff <= 1'b0;
		end else begin
			ack_ff <= req && !ack_ff;
		end
	end

	// read mux; unmapped offsets read zero and ignore writes
	always_comb begin
		nxt_rdat = RST_ZERO;
		unique case (wb_adr_in)
			OFS_OPERATION_BIT_MASK: nxt_rdat = operation_bit_mask_ff;
			OFS_COMBO: nxt_rdat = {combo_ff, 28'h000_0000};
			OFS_LINE_CTRL: nxt_rdat = line_ctrl_ff;
			OFS_LINE_FG: nxt_rdat = line_fg_ff;
			OFS_LINE_BG: nxt_rdat = line_bg_ff;
			OFS_LINE_STYLE: nxt_rdat = style_ff;
			OFS_CHAR_CTRL: nxt_rdat = char_ctrl_ff;
			OFS_CHAR_FG: nxt_rdat = char_fg_ff;
			OFS_CHAR_BG: nxt_rdat = char_bg_ff;
			OFS_FORM_MASK: nxt_rdat = form_mask_ff;
			OFS_STATUS: nxt_rdat[ST_IDX_LO +: 5] = pat_idx_ff;
			default: nxt_rdat = RST_ZERO;
		endcase
		if (wb_adr_in == OFS_STATUS) begin
			nxt_rdat[ST_HIT] = hit_ff;
		end
		for (int i = 0; i < PTR_WORDS; i++) begin
			if (wb_adr_in == OFS_PTR_BASE + ADR_W'(4 * i)) begin
				nxt_rdat = ptr_ff[i];
			end
		end
		for (int i = 0; i < PAL_WORDS; i++) begin
			if (wb_adr_in == OFS_PAL_BASE + ADR_W'(4 * i)) begin
				nxt_rdat = {pal_ff[i], {(WORD_W - PAL_W){1'b0}}};
			end
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			rdat_ff <= RST_ZERO;
		end else if (req && !ack_ff && !wb_we_in) begin
			rdat_ff <= nxt_rdat;
		end
	end

	// ==========================================================
	// attribute words; segment packets overwrite style and colours
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			operation_bit_mask_ff <= RST_ONES;
			form_mask_ff <= RST_ONES;
			combo_ff <= RULE_COPY;
			line_ctrl_ff <= RST_ZERO;
			line_fg_ff <= RST_ONES;
			line_bg_ff <= RST_ZERO;
			style_ff <= RST_ONES;
			char_ctrl_ff <= RST_ZERO;
			char_fg_ff <= RST_ONES;
			char_bg_ff <= RST_ZERO;
		end else begin
			if (wr_now) begin
				unique case (wb_adr_in)
					OFS_OPERATION_BIT_MASK: operation_bit_mask_ff <= merge(operation_bit_mask_ff, wdat, wb_sel_in);
					OFS_FORM_MASK:
						form_mask_ff <= merge(form_mask_ff, wdat, wb_sel_in);
					OFS_COMBO: if (wb_sel_in[3]) combo_ff <= wdat[31:28];
					OFS_LINE_CTRL:
						line_ctrl_ff <= merge(line_ctrl_ff, wdat, wb_sel_in);
					OFS_LINE_FG: line_fg_ff <= merge(line_fg_ff, wdat, wb_sel_in);
					OFS_LINE_BG: line_bg_ff <= merge(line_bg_ff, wdat, wb_sel_in);
					OFS_LINE_STYLE: style_ff <= merge(style_ff, wdat, wb_sel_in);
					OFS_CHAR_CTRL:
						char_ctrl_ff <= merge(char_ctrl_ff, wdat, wb_sel_in);
					OFS_CHAR_FG: char_fg_ff <= merge(char_fg_ff, wdat, wb_sel_in);
					OFS_CHAR_BG: char_bg_ff <= merge(char_bg_ff, wdat, wb_sel_in);
					default: ;
				endcase
			end
			// packet wins; the words are undefined to software meanwhile
			if (seg_valid_in) begin
				style_ff <= seg_in.style;
				line_fg_ff <= seg_in.fg;
				line_bg_ff <= seg_in.bg;
			end
		end
	end

	// pointer descriptor; cross-hair coordinates are clipped on entry
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			for (int i = 0; i < PTR_WORDS; i++) begin
				ptr_ff[i] <= RST_ZERO;
			end
		end else if (wr_now) begin
			for (int i = 0; i < PTR_WORDS; i++) begin
				if (wb_adr_in == OFS_PTR_BASE + ADR_W'(4 * i)) begin
					if (i == PD_FLAGS || !ptr_ff[PD_FLAGS][PF_CROSS]) begin
						ptr_ff[i] <= merge(ptr_ff[i], wdat, wb_sel_in);
					end else if (i[0]) begin
						ptr_ff[i] <= clip(merge(ptr_ff[i], wdat, wb_sel_in),
							MAX_X);
					end else begin
						ptr_ff[i] <= clip(merge(ptr_ff[i], wdat, wb_sel_in),
							MAX_Y);
					end
				end
			end
		end
	end

	// palette entry: four words, leftmost PAL_W bits kept per word
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			for (int i = 0; i < PAL_WORDS; i++) begin
				pal_ff[i] <= '0;
			end
		end else if (wr_now && wb_sel_in[3]) begin
			for (int i = 0; i < PAL_WORDS; i++) begin
				if (wb_adr_in == OFS_PAL_BASE + ADR_W'(4 * i)) begin
					pal_ff[i] <= wdat[WORD_W-1 -: PAL_W];
				end
			end
		end
	end

	// ==========================================================
	// pixel path
	logic line_px, style_bit, suppress, may_hit;
	logic ptr_visible, ptr_cross, ptr_image;
	logic signed [WORD_W:0] img_right, img_bottom;
	logic [WORD_W-1:0] src_col, comb_mask, planted;

	assign line_px = pix_valid_in && !pix_in.is_char;
	assign style_bit = style_ff[pat_idx_ff];
	assign ptr_visible = ptr_ff[PD_FLAGS][PF_VISIBLE];
	// both type bits set is left to software; cross wins here
	assign ptr_cross = ptr_ff[PD_FLAGS][PF_CROSS];
	assign ptr_image = ptr_ff[PD_FLAGS][PF_IMAGE] && !ptr_cross;
	assign img_right = (WORD_W+1)'($signed(ptr_ff[PD_LEFT])) +
		(WORD_W+1)'({1'b0, ptr_ff[PD_WIDTH]}) - (WORD_W+1)'(1);
	assign img_bottom = (WORD_W+1)'($signed(ptr_ff[PD_TOP])) +
		(WORD_W+1)'({1'b0, ptr_ff[PD_HEIGHT]}) - (WORD_W+1)'(1);

	// colour and suppression; the vertex uses whatever segment is loaded
	always_comb begin
		if (pix_in.is_char) begin
			src_col = pix_in.cell_bit ? char_fg_ff : char_bg_ff;
			suppress = pix_in.cell_bit ? char_ctrl_ff[CC_SUP_FG] :
				char_ctrl_ff[CC_SUP_BG];
		end else begin
			src_col = style_bit ? line_fg_ff : line_bg_ff;
			suppress = (style_bit ? line_ctrl_ff[LC_SUP_FG] :
				line_ctrl_ff[LC_SUP_BG]) ||
				(pix_in.first_pt && line_ctrl_ff[LC_SUP_INIT]) ||
				(pix_in.last_pt && line_ctrl_ff[LC_SUP_FINAL]);
		end
	end

	// overlap test against the visible pointer
	always_comb begin
		may_hit = 1'b0;
		if (ptr_visible && ptr_cross) begin
			may_hit = (in_span(pix_in.x, ptr_ff[PD_HSX], ptr_ff[PD_HEX]) &&
				in_span(pix_in.y, ptr_ff[PD_HSY], ptr_ff[PD_HEY])) ||
				(in_span(pix_in.x, ptr_ff[PD_VSX], ptr_ff[PD_VEX]) &&
				in_span(pix_in.y, ptr_ff[PD_VSY], ptr_ff[PD_VEY]));
		end else if (ptr_visible && ptr_image) begin
			// signed on both sides, so pixels left of or above zero compare right
			may_hit = ($signed({pix_in.x[WORD_W-1], pix_in.x}) >=
				(WORD_W+1)'($signed(ptr_ff[PD_LEFT]))) &&
				($signed({pix_in.x[WORD_W-1], pix_in.x}) <= img_right) &&
				($signed({pix_in.y[WORD_W-1], pix_in.y}) >=
				(WORD_W+1)'($signed(ptr_ff[PD_TOP]))) &&
				($signed({pix_in.y[WORD_W-1], pix_in.y}) <= img_bottom);
		end
	end

	assign comb_mask = operation_bit_mask_ff & form_mask_ff;
	assign planted = (comb_mask & apply_rule(combo_ff, src_col, pix_in.dest)) |
		(~comb_mask & pix_in.dest);

	// pattern pointer: msb at command start, steps every line pixel
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			pat_idx_ff <= PAT_MSB;
		end else if (start_cmd) begin
			pat_idx_ff <= PAT_MSB;
		end else if (line_px) begin
			if (pat_idx_ff == PAT_LSB) begin
				pat_idx_ff <= PAT_MSB;
			end else begin
				pat_idx_ff <= pat_idx_ff - PAT_STEP;
			end
		end
	end

	// sticky hit; a new hit in the clearing cycle wins
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			hit_ff <= 1'b0;
		end else if (pix_valid_in && may_hit) begin
			hit_ff <= 1'b1;
		end else if (hit_clear) begin
			hit_ff <= 1'b0;
		end
	end

	// result register; while a hit stands no pixel is written
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			pix_done_out <= 1'b0;
			pix_we_out <= 1'b0;
			pix_data_out <= RST_ZERO;
		end else begin
			pix_done_out <= pix_valid_in;
			pix_we_out <= pix_valid_in && !suppress && !may_hit &&
				!hit_ff;
			pix_data_out <= suppress ? pix_in.dest : planted;
		end
	end

	assign wb_ack_out = ack_ff;
	assign wb_dat_out = rdat_ff;
	assign pointer_hit_out = hit_ff;

	// ==========================================================
	// checks
	chk_ack_single: assert property (@(posedge clk_in) disable iff (rst_in)
		ack_ff |=> !ack_ff) else $error("ack held too long");
	chk_ack_latency: assert property (@(posedge clk_in) disable iff (rst_in)
		req && !ack_ff |=> ack_ff) else $error("ack missing");
	chk_pattern_step: assert property (@(posedge clk_in) disable iff (rst_in)
		line_px && !start_cmd && pat_idx_ff != PAT_LSB |=>
		pat_idx_ff == $past(pat_idx_ff) - PAT_STEP)
		else $error("pattern pointer did not step");
	chk_pattern_wrap: assert property (@(posedge clk_in) disable iff (rst_in)
		line_px && !start_cmd && pat_idx_ff == PAT_LSB |=>
		pat_idx_ff == PAT_MSB) else $error("pattern did not wrap");
	chk_start_msb: assert property (@(posedge clk_in) disable iff (rst_in)
		start_cmd |=> pat_idx_ff == PAT_MSB)
		else $error("pattern not reset at start");
	chk_line_colour: assert property (@(posedge clk_in) disable iff (rst_in)
		line_px && comb_mask == RST_ONES && combo_ff == RULE_COPY &&
		!suppress |=> pix_data_out == $past(style_bit ? line_fg_ff :
		line_bg_ff)) else $error("wrong line colour");
	chk_supp_nowrite: assert property (@(posedge clk_in) disable iff (rst_in)
		pix_valid_in && suppress |=> pix_done_out && !pix_we_out)
		else $error("suppressed pixel written");
	chk_single_point: assert property (@(posedge clk_in) disable iff (rst_in)
		line_px && pix_in.first_pt && pix_in.last_pt &&
		(line_ctrl_ff[LC_SUP_INIT] || line_ctrl_ff[LC_SUP_FINAL]) |=>
		!pix_we_out) else $error("single point drawn");
	chk_char_supp: assert property (@(posedge clk_in) disable iff (rst_in)
		pix_valid_in && pix_in.is_char && pix_in.cell_bit &&
		char_ctrl_ff[CC_SUP_FG] |=> !pix_we_out)
		else $error("glyph fg not suppressed");
	chk_hit_blocks: assert property (@(posedge clk_in) disable iff (rst_in)
		pix_valid_in && may_hit |=> hit_ff && !pix_we_out ##1 hit_ff)
		else $error("pointer overlap not caught");
	chk_mask_keeps: assert property (@(posedge clk_in) disable iff (rst_in)
		pix_valid_in |=> ((pix_data_out ^ $past(pix_in.dest)) &
		~$past(comb_mask)) == RST_ZERO) else $error("masked bits changed");
	chk_pal_zero: assert property (@(posedge clk_in) disable iff (rst_in)
		ack_ff && !wb_we_in && wb_adr_in >= OFS_PAL_BASE |->
		wb_dat_out[WORD_W-PAL_W-1:0] == '0)
		else $error("palette low bits not zero");
	cov_line_write: cover property (@(posedge clk_in) disable iff (rst_in)
		line_px ##1 pix_we_out);
	cov_char_write: cover property (@(posedge clk_in) disable iff (rst_in)
		pix_valid_in && pix_in.is_char ##1 pix_we_out);
	cov_wrap: cover property (@(posedge clk_in) disable iff (rst_in)
		line_px && pat_idx_ff == PAT_LSB);
	cov_hit: cover property (@(posedge clk_in) disable iff (rst_in)
		pix_valid_in && may_hit);
endmodule // glyph_pixel_attr
`default_nettype wire

//--- verif/dest_bitmap_model.sv
// destination bitmap model: pixel store read by x, written on pixel strobe
`timescale 1ns/1ps
`default_nettype none
module dest_bitmap_model (
	input wire logic clk_in,
	input wire logic pix_valid_in,
	input wire logic [7:0] x_in,
	input wire logic we_in,
	input wire logic [31:0] data_in,
	output logic [31:0] dest_out
);
	logic [31:0] mem_ff [256];
	logic [7:0] wr_x_ff;
	// ==========================================================
	// storage
	// known start pattern so the bench can predict untouched pixels
	initial begin
		for (int i = 0; i < 256; i++) begin
			mem_ff[i] = {16'hC3A5, 8'h00, i[7:0]};
		end
	end
	assign dest_out = mem_ff[x_in];
	// the write strobe comes a cycle after the request, so keep its x
	always @(posedge clk_in) begin
		if (pix_valid_in) begin
			wr_x_ff <= x_in;
		end
		if (we_in) begin
			mem_ff[wr_x_ff] <= data_in;
		end
	end
endmodule // dest_bitmap_model
`default_nettype wire

//--- verif/tb_top.sv
// self-checking bench for the polyline and glyph pixel attribute unit
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import glyph_attr_pkg::*;
;
	logic clk_in, rst_in, wb_cyc, wb_stb, wb_we, wb_ack, pv, sv, done, pwe, hit;
	logic blk; // pixel stopped by the pointer: data still carries the plant
	logic [3:0] fl, rule, wb_sel;
	logic [ADR_W-1:0] wb_adr;
	logic [WORD_W-1:0] wb_wd, wb_rd, pdata, dest, rd, cm, fg, bg, sty;
	logic signed [WORD_W-1:0] px, py;
	seg_attr_s seg;
	pix_req_s pix;
	int num_errors, n_compared, k;
	assign pix = {fl, px, py, dest};
	glyph_pixel_attr i_glyph_pixel_attr (.clk_in(clk_in), .rst_in(rst_in),
		.wb_cyc_in(wb_cyc), .wb_stb_in(wb_stb), .wb_we_in(wb_we),
		.wb_adr_in(wb_adr), .wb_sel_in(wb_sel), .wb_dat_in(wb_wd),
		.wb_ack_out(wb_ack), .wb_dat_out(wb_rd), .pix_valid_in(pv),
		.pix_in(pix), .seg_valid_in(sv), .seg_in(seg), .pix_done_out(done),
		.pix_we_out(pwe), .pix_data_out(pdata), .pointer_hit_out(hit));
	dest_bitmap_model i_dest_bitmap_model (.clk_in(clk_in), .pix_valid_in(pv),
		.x_in(px[7:0]), .we_in(pwe), .data_in(pdata), .dest_out(dest));
	initial begin
		clk_in = 1'b0;
		forever #2.5 clk_in = ~clk_in;
	end
	// ==========================================================
	// helpers
	task automatic summarize();
		$display("compared %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic check(input logic [31:0] got, exp, input string msg);
		n_compared++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask
	// combination rule per bit: rule bit index is {not src, not dest}
	function automatic logic [31:0] rl(input logic [31:0] s, d);
		for (int i = 0; i < 32; i++) begin
			rl[i] = rule[{~s[i], ~d[i]}];
		end
	endfunction
	// classic cycle: hold everything until ack is sampled high
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_in);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= a;
		wb_wd <= d;
		n = 0;
		do begin
			@(posedge clk_in);
			n++;
		end while (wb_ack !== 1'b1 && n < 20);
		if (wb_ack !== 1'b1) begin
			num_errors++;
			$display("[FAIL] %0t bus answer missing", $time);
			summarize();
		end
		rd = wb_rd;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		wb(1'b1, a, d);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string m);
		wb(1'b0, a, RST_ZERO);
		check(rd, e, m);
	endtask
	task automatic wp(input int idx, input logic [31:0] d);
		wr(8'(OFS_PTR_BASE + 4 * idx), d);
	endtask
	// one pixel on a fresh x; the answer stands exactly one cycle later
	task automatic pixel(input logic [3:0] f, input logic [3:0] y,
		input logic draw, input logic [31:0] src, input string msg);
		logic [31:0] d, e;
		@(posedge clk_in);
		fl <= f;
		py <= {28'h000_0000, y};
		px <= px + 1;
		pv <= 1'b1;
		@(posedge clk_in);
		pv <= 1'b0;
		#1;
		d = {16'hC3A5, 8'h00, px[7:0]};
		e = (draw || blk) ? ((cm & rl(src, d)) | (~cm & d)) : d;
		check(32'(done), 32'h0000_0001, msg);
		check(32'(pwe), 32'(draw), msg);
		check(pdata, e, msg);
	endtask
	// ==========================================================
	// main sequence
	initial begin
		{rst_in, wb_cyc, wb_stb, wb_we, pv, sv} = 6'h20;
		{wb_adr, wb_wd, px, py, fl, seg} = '0;
		wb_sel = 4'hF;
		cm = RST_ONES;
		rule = RULE_COPY;
		blk = 1'b0;
		num_errors = 0;
		n_compared = 0;
		repeat (5) @(posedge clk_in);
		rst_in <= 1'b0;
		rdc(OFS_OPERATION_BIT_MASK, RST_ONES, "operation_bit_mask reset");
		rdc(OFS_LINE_BG, RST_ZERO, "line bg reset");
		rdc(OFS_STATUS, 32'h0000_1F00, "status reset");
		wr(8'hFC, 32'h1234_5678);
		rdc(8'hFC, RST_ZERO, "unmapped");
		$display("test registers done");
		fg = 32'h0000_00F1;
		bg = 32'h0000_0B02;
		sty = 32'hA5C3_0F01;
		wr(OFS_LINE_FG, fg);
		wr(OFS_LINE_BG, bg);
		wr(OFS_LINE_STYLE, sty);
		wr(OFS_CONTROL, 32'h0000_0001);
		for (k = 0; k < 40; k++) begin
			if (k == 12) begin
				fg = 32'h0000_A0A0;
				bg = 32'h0000_0505;
				sty = 32'h0FF0_3C5A;
				@(posedge clk_in);
				seg <= '{style: sty, fg: fg, bg: bg};
				sv <= 1'b1;
				@(posedge clk_in);
				sv <= 1'b0;
			end
			pixel(4'h0, 4'h0, 1'b1, sty[31 - (k % 32)] ? fg : bg, "style");
		end
		wr(OFS_CONTROL, 32'h0000_0001);
		pixel(4'h0, 4'h0, 1'b1, sty[31] ? fg : bg, "restart");
		$display("test style done");
		sty = 32'hAAAA_AAAA;
		wr(OFS_LINE_STYLE, sty);
		for (k = 0; k < 5; k++) begin
			wr(OFS_LINE_CTRL, (k < 4) ? (32'h0000_0001 << k) : RST_ZERO);
			wr(OFS_CONTROL, 32'h0000_0001);
			pixel(4'h0, 4'h0, k != 0, fg, "fg suppress");
			pixel(4'h0, 4'h0, k != 1, bg, "bg suppress");
			pixel(4'h2, 4'h0, k != 0 && k != 2, fg, "initial");
			pixel(4'h1, 4'h0, k != 1 && k != 3, bg, "final");
			pixel(4'h3, 4'h0, k == 1 || k == 4, fg, "single point");
		end
		wr(OFS_LINE_CTRL, RST_ZERO);
		$display("test suppression done");
		wr(OFS_LINE_STYLE, RST_ONES);
		wr(OFS_OPERATION_BIT_MASK, 32'h0000_FF0F);
		wr(OFS_FORM_MASK, 32'hFFFF_00FF);
		cm = 32'h0000_000F;
		for (k = 0; k < 16; k++) begin
			rule = k[3:0];
			wr(OFS_COMBO, {rule, 28'h000_0000});
			pixel(4'h0, 4'h0, 1'b1, fg, "rule and masks");
		end
		wr(OFS_OPERATION_BIT_MASK, RST_ONES);
		wr(OFS_FORM_MASK, RST_ONES);
		wr(OFS_COMBO, 32'h3000_0000);
		cm = RST_ONES;
		rule = RULE_COPY;
		$display("test rules done");
		wr(OFS_CHAR_FG, 32'h0000_0C0C);
		wr(OFS_CHAR_BG, 32'h0000_0303);
		for (k = 0; k < 4; k++) begin
			wr(OFS_CHAR_CTRL, 32'(k));
			pixel(4'hC, 4'h0, !k[0], 32'h0000_0C0C, "glyph fg");
			pixel(4'h8, 4'h0, !k[1], 32'h0000_0303, "glyph bg");
		end
		wr(OFS_CHAR_CTRL, RST_ZERO);
		$display("test glyph done");
		wp(PD_FLAGS, 32'h0000_0005);
		wp(PD_LEFT, RST_ZERO);
		wp(PD_TOP, 32'h0000_0003);
		wp(PD_WIDTH, 32'h0000_00FA);
		wp(PD_HEIGHT, 32'h0000_0004);
		blk = 1'b1;
		pixel(4'h0, 4'h5, 1'b0, fg, "pointer overlap");
		check(32'(hit), 32'h0000_0001, "hit raised");
		pixel(4'h0, 4'h0, 1'b0, fg, "blocked while hit");
		blk = 1'b0;
		wp(PD_FLAGS, RST_ZERO);
		wr(OFS_STATUS, 32'h0000_0001);
		#1;
		check(32'(hit), RST_ZERO, "hit cleared");
		pixel(4'h0, 4'h5, 1'b1, fg, "invisible pointer");
		wp(PD_FLAGS, 32'h0000_0002);
		wp(PD_HSX, 32'hFFFF_FFFB);
		wp(PD_HEX, 32'h0000_1388);
		wp(PD_VEY, 32'h0000_0FFF);
		rdc(8'(OFS_PTR_BASE + 4 * PD_HSX), RST_ZERO, "clip left");
		rdc(8'(OFS_PTR_BASE + 4 * PD_HEX), 32'h0000_03FF, "clip right");
		rdc(8'(OFS_PTR_BASE + 4 * PD_VEY), 32'h0000_02FF, "clip bottom");
		wp(PD_HSY, 32'h0000_0007);
		wp(PD_HEY, 32'h0000_0007);
		wp(PD_FLAGS, 32'h0000_0003);
		pixel(4'h0, 4'h0, 1'b1, fg, "cross miss");
		blk = 1'b1;
		pixel(4'h0, 4'h7, 1'b0, fg, "cross hit");
		blk = 1'b0;
		check(32'(hit), 32'h0000_0001, "cross hit raised");
		wp(PD_FLAGS, RST_ZERO);
		wr(OFS_STATUS, 32'h0000_0001);
		$display("test pointer done");
		for (k = 0; k < PAL_WORDS; k++) begin
			wr(8'(OFS_PAL_BASE + 4 * k), {8'(8'hA0 + k), 24'h12_3456});
			rdc(8'(OFS_PAL_BASE + 4 * k), {8'(8'hA0 + k), 24'h00_0000}, "palette");
		end
		$display("test palette done");
		summarize();
	end
endmodule // tb_top
`default_nettype wire
